// File: dtc_params.svh
// constants of the gate control logic
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH
`define DTC_CLK_NS 10
`define DTC_FRAME_BITS 16
`define DTC_OP_MSB 15
`define DTC_OP_LSB 12
`define DTC_OP_NOP 4'h0
`define DTC_OP_CLR_INT 4'h1
`define DTC_OP_MASK_LO 4'h2
`define DTC_OP_MASK_HI 4'h3
`define DTC_OP_DEADTIME 4'h4
`define DTC_OP_FULLON 4'h5
`define DTC_MASK_RST 4'h0
`define DTC_DT_RST 8'h04
`define DTC_FULLON_BIT 0
`define DTC_DT_STEP_NS 50
`define DTC_DT_STEP_CYC ((`DTC_DT_STEP_NS + `DTC_CLK_NS - 1) / `DTC_CLK_NS)
`define DTC_DT_MAX_NS 12000
`define DTC_DT_MAX_STEPS 8'(`DTC_DT_MAX_NS / `DTC_DT_STEP_NS)
`define DTC_CNT_W 11
`define DTC_RST_NS 77
`define DTC_RST_CYC (`DTC_RST_NS / `DTC_CLK_NS)
`define DTC_SYNC_LAT_CYC 3
`endif

// File: dtc_pkg.sv
// types of the gate control logic
`include "dtc_params.svh"
package dtc_pkg;
  typedef enum logic [4:0] {
    DTC_PH_OFF = 5'b00001,
    DTC_PH_WAIT_HI = 5'b00010,
    DTC_PH_HI_ON = 5'b00100,
    DTC_PH_WAIT_LO = 5'b01000,
    DTC_PH_LO_ON = 5'b10000
  } dtc_ph_st_t;

  typedef struct packed {
    logic [1:0] en1_sync;
    logic [1:0] en2_sync;
    logic [1:0] rstn_sync;
    logic [1:0] por_sync;
    logic [1:0] cs_sync;
    logic [1:0] oc_sync;
    logic [2:0] tgl_sync;
    logic [1:0][2:0] hs_sync;
    logic [1:0][2:0] ls_sync;
    logic [1:0][2:0] phc_sync;
    logic [1:0][7:0] fault_sync;
    logic [2:0] hi_prev;
    logic [2:0] lo_prev;
    dtc_ph_st_t [2:0] ph;
    logic [2:0][`DTC_CNT_W-1:0] cnt;
    logic [2:0] primed;
    logic [2:0] hi_gate;
    logic [2:0] lo_gate;
    logic [7:0] fault_lat;
    logic [3:0] mask_lo;
    logic [3:0] mask_hi;
    logic [7:0] dt_steps;
    logic fullon;
    logic fullon_lock;
    logic irq;
    logic oc;
    logic [2:0] phase;
    logic [15:0] status;
  } dtc_core_t;

  typedef struct packed {
    logic [15:0] shift;
    logic [15:0] cmd;
    logic tgl;
  } dtc_link_t;
endpackage

// File: dtc_gate_ctrl.sv
// gate control logic of a three phase pre-driver
// Notes on behaviour
// - gates on only with both enables high
// - enable low forces gates off asynchronously
// - high side waits for low side pulse
// - reset pin low: outputs off, pull-down
// - internal reset within 77 ns
// - power-on clear: reset, high-Z, ignore serial
// - phase output follows half-supply comparator
// - high side commands are active low
// - low side commands are active high
// - interrupt latched until clear command
// - two mask registers gate fault interrupts
// - serial accepted only while select low
// - serial input sampled falling edge, msb first
// - serial output high-Z while select high
// - serial output changes on rising edge
// - overcurrent output follows comparator
// - leading edge: other off, deadtime, on
// - simultaneous turn-on set once per reset
// - deadtime in 50 ns steps up to 12 us
`timescale 1ns/10ps
`include "dtc_params.svh"
module dtc_gate_ctrl (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  input wire logic gate_enable_first_i,
  input wire logic gate_enable_second_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic high_side_cmd_n_a_i,
  input wire logic high_side_cmd_n_b_i,
  input wire logic high_side_cmd_n_c_i,
  input wire logic low_side_cmd_a_i,
  input wire logic low_side_cmd_b_i,
  input wire logic low_side_cmd_c_i,
  input wire logic [2:0] phase_cmp_i,
  input wire logic [7:0] fault_src_i,
  input wire logic oc_cmp_i,
  output logic high_gate_out_a_o,
  output logic high_gate_out_b_o,
  output logic high_gate_out_c_o,
  output logic low_gate_out_a_o,
  output logic low_gate_out_b_o,
  output logic low_gate_out_c_o,
  output logic gate_oe_n_o,
  output logic gate_pulldown_o,
  output logic phase_level_out_a_o,
  output logic phase_level_out_b_o,
  output logic phase_level_out_c_o,
  output logic fault_int_o,
  output logic overcurrent_flag_out_o
);

  function automatic logic dtc_is_op(input logic [15:0] word, input logic [3:0] op);
    dtc_is_op = (word[`DTC_OP_MSB:`DTC_OP_LSB] == op);
  endfunction

  dtc_pkg::dtc_core_t r;
  dtc_pkg::dtc_core_t r_nxt;
  dtc_pkg::dtc_link_t l_r;
  dtc_pkg::dtc_link_t l_nxt;
  logic [3:0] bit_cnt_r;
  logic so_r;
  logic [2:0] hs_n_in;
  logic [2:0] ls_in;
  logic gate_ok;

  assign hs_n_in = {high_side_cmd_n_c_i, high_side_cmd_n_b_i, high_side_cmd_n_a_i};
  assign ls_in = {low_side_cmd_c_i, low_side_cmd_b_i, low_side_cmd_a_i};

  // pin-level kill path, no clock involved
  assign gate_ok = gate_enable_first_i & gate_enable_second_i & rst_n_i & por_n_i;

  assign high_gate_out_a_o = r.hi_gate[0] & gate_ok;
  assign high_gate_out_b_o = r.hi_gate[1] & gate_ok;
  assign high_gate_out_c_o = r.hi_gate[2] & gate_ok;
  assign low_gate_out_a_o = r.lo_gate[0] & gate_ok;
  assign low_gate_out_b_o = r.lo_gate[1] & gate_ok;
  assign low_gate_out_c_o = r.lo_gate[2] & gate_ok;
  assign gate_pulldown_o = ~rst_n_i;
  assign gate_oe_n_o = ~por_n_i;
  assign phase_level_out_a_o = r.phase[0];
  assign phase_level_out_b_o = r.phase[1];
  assign phase_level_out_c_o = r.phase[2];
  assign fault_int_o = r.irq;
  assign overcurrent_flag_out_o = r.oc;
  assign so_o = so_r;
  assign so_oe_n_o = cs_n_i | ~por_n_i;

  // link side: bit counter restarts whenever select goes high
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_comb begin
    l_nxt = l_r;
    if (!cs_n_i) begin
      l_nxt.shift = {l_r.shift[14:0], si_i};
      if (bit_cnt_r == 4'hF) begin
        l_nxt.cmd = {l_r.shift[14:0], si_i};
        l_nxt.tgl = ~l_r.tgl;
      end
    end
  end

  always_ff @(negedge sclk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // status word is frozen in the core domain while a frame runs
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_r <= 1'b0;
    end else begin
      so_r <= r.status[4'hF - bit_cnt_r];
    end
  end

  // core side
  always_comb begin
    logic rst_int;
    logic en_ok;
    logic cmd_new;
    logic clr;
    logic hi_cmd;
    logic lo_cmd;
    logic [`DTC_CNT_W-1:0] dt_cyc;
    rst_int = 1'b0;
    en_ok = 1'b0;
    cmd_new = 1'b0;
    clr = 1'b0;
    hi_cmd = 1'b0;
    lo_cmd = 1'b0;
    dt_cyc = '0;
    r_nxt = r;
    r_nxt.en1_sync = {r.en1_sync[0], gate_enable_first_i};
    r_nxt.en2_sync = {r.en2_sync[0], gate_enable_second_i};
    r_nxt.rstn_sync = {r.rstn_sync[0], rst_n_i};
    r_nxt.por_sync = {r.por_sync[0], por_n_i};
    r_nxt.cs_sync = {r.cs_sync[0], cs_n_i};
    r_nxt.oc_sync = {r.oc_sync[0], oc_cmp_i};
    r_nxt.tgl_sync = {r.tgl_sync[1:0], l_r.tgl};
    r_nxt.hs_sync = {r.hs_sync[0], hs_n_in};
    r_nxt.ls_sync = {r.ls_sync[0], ls_in};
    r_nxt.phc_sync = {r.phc_sync[0], phase_cmp_i};
    r_nxt.fault_sync = {r.fault_sync[0], fault_src_i};
    r_nxt.phase = r.phc_sync[1];
    r_nxt.oc = r.oc_sync[1];
    // sync depth keeps internal reset within the limit
    rst_int = reset_i | ~r.rstn_sync[1] | ~r.por_sync[1];
    en_ok = r.en1_sync[1] & r.en2_sync[1];
    cmd_new = (r.tgl_sync[2] ^ r.tgl_sync[1]) & ~rst_int;
    dt_cyc = `DTC_CNT_W'(r.dt_steps) * `DTC_CNT_W'(`DTC_DT_STEP_CYC);
    if (rst_int) begin
      r_nxt.hi_prev = 3'h0;
      r_nxt.lo_prev = 3'h0;
      r_nxt.ph = '{default: dtc_pkg::DTC_PH_OFF};
      r_nxt.phase = 3'h0;
      r_nxt.oc = 1'b0;
      r_nxt.cnt = '0;
      r_nxt.primed = 3'h0;
      r_nxt.hi_gate = 3'h0;
      r_nxt.lo_gate = 3'h0;
      r_nxt.fault_lat = 8'h00;
      r_nxt.mask_lo = `DTC_MASK_RST;
      r_nxt.mask_hi = `DTC_MASK_RST;
      r_nxt.dt_steps = `DTC_DT_RST;
      r_nxt.fullon = 1'b0;
      r_nxt.fullon_lock = 1'b0;
      r_nxt.irq = 1'b0;
    end else begin
      if (cmd_new) begin
        clr = dtc_is_op(l_r.cmd, `DTC_OP_CLR_INT);
        if (dtc_is_op(l_r.cmd, `DTC_OP_MASK_LO)) begin
          r_nxt.mask_lo = l_r.cmd[3:0];
        end
        if (dtc_is_op(l_r.cmd, `DTC_OP_MASK_HI)) begin
          r_nxt.mask_hi = l_r.cmd[3:0];
        end
        if (dtc_is_op(l_r.cmd, `DTC_OP_DEADTIME)) begin
          if (l_r.cmd[7:0] > `DTC_DT_MAX_STEPS) begin
            r_nxt.dt_steps = `DTC_DT_MAX_STEPS;
          end else begin
            r_nxt.dt_steps = l_r.cmd[7:0];
          end
        end
        if (dtc_is_op(l_r.cmd, `DTC_OP_FULLON) && !r.fullon_lock) begin
          r_nxt.fullon = l_r.cmd[`DTC_FULLON_BIT];
          r_nxt.fullon_lock = 1'b1;
        end
      end
      // a fault in the clearing cycle survives the clear
      r_nxt.fault_lat = (clr ? 8'h00 : r.fault_lat) | r.fault_sync[1];
      r_nxt.irq = (r.irq & ~clr) | (|(r.fault_sync[1] & ~{r.mask_hi, r.mask_lo}));
      for (int p = 0; p < 3; p++) begin
        hi_cmd = ~r.hs_sync[1][p];
        lo_cmd = r.ls_sync[1][p];
        r_nxt.hi_prev[p] = hi_cmd;
        r_nxt.lo_prev[p] = lo_cmd;
        if (!en_ok) begin
          r_nxt.ph[p] = dtc_pkg::DTC_PH_OFF;
          r_nxt.hi_gate[p] = 1'b0;
          r_nxt.lo_gate[p] = 1'b0;
          r_nxt.primed[p] = 1'b0;
        end else if (r.fullon) begin
          // blanking bypassed, priming still required
          r_nxt.ph[p] = dtc_pkg::DTC_PH_OFF;
          r_nxt.hi_gate[p] = hi_cmd & r.primed[p];
          r_nxt.lo_gate[p] = lo_cmd;
          if (lo_cmd) begin
            r_nxt.primed[p] = 1'b1;
          end
        end else if (hi_cmd && !r.hi_prev[p] && r.primed[p]) begin
          r_nxt.lo_gate[p] = 1'b0;
          r_nxt.ph[p] = dtc_pkg::DTC_PH_WAIT_HI;
          r_nxt.cnt[p] = dt_cyc;
        end else if (lo_cmd && !r.lo_prev[p]) begin
          r_nxt.hi_gate[p] = 1'b0;
          r_nxt.ph[p] = dtc_pkg::DTC_PH_WAIT_LO;
          r_nxt.cnt[p] = dt_cyc;
        end else begin
          case (r.ph[p])
            dtc_pkg::DTC_PH_OFF: begin
              r_nxt.hi_gate[p] = 1'b0;
              r_nxt.lo_gate[p] = 1'b0;
            end
            dtc_pkg::DTC_PH_WAIT_HI: begin
              if (!hi_cmd) begin
                r_nxt.ph[p] = dtc_pkg::DTC_PH_OFF;
              end else if (r.cnt[p] == '0) begin
                r_nxt.hi_gate[p] = 1'b1;
                r_nxt.ph[p] = dtc_pkg::DTC_PH_HI_ON;
              end else begin
                r_nxt.cnt[p] = r.cnt[p] - `DTC_CNT_W'(1);
              end
            end
            dtc_pkg::DTC_PH_HI_ON: begin
              if (!hi_cmd) begin
                r_nxt.hi_gate[p] = 1'b0;
                r_nxt.ph[p] = dtc_pkg::DTC_PH_OFF;
              end
            end
            dtc_pkg::DTC_PH_WAIT_LO: begin
              if (!lo_cmd) begin
                r_nxt.ph[p] = dtc_pkg::DTC_PH_OFF;
              end else if (r.cnt[p] == '0) begin
                r_nxt.lo_gate[p] = 1'b1;
                r_nxt.primed[p] = 1'b1;
                r_nxt.ph[p] = dtc_pkg::DTC_PH_LO_ON;
              end else begin
                r_nxt.cnt[p] = r.cnt[p] - `DTC_CNT_W'(1);
              end
            end
            dtc_pkg::DTC_PH_LO_ON: begin
              if (!lo_cmd) begin
                r_nxt.lo_gate[p] = 1'b0;
                r_nxt.ph[p] = dtc_pkg::DTC_PH_OFF;
              end
            end
            default: begin
              r_nxt.ph[p] = dtc_pkg::DTC_PH_OFF;
              r_nxt.hi_gate[p] = 1'b0;
              r_nxt.lo_gate[p] = 1'b0;
            end
          endcase
        end
      end
    end
    // snapshot only while no frame runs so the link reads a still word
    if (r.cs_sync[1]) begin
      r_nxt.status = {r.irq, r.fullon_lock, r.fullon, r.primed, 2'h0, r.fault_lat};
    end
    if (reset_i) begin
      r_nxt = '0;
      r_nxt.ph = '{default: dtc_pkg::DTC_PH_OFF};
      // keep the toggle synchroniser running so a reset cannot replay the last command
      r_nxt.tgl_sync = {r.tgl_sync[1:0], l_r.tgl};
      r_nxt.dt_steps = `DTC_DT_RST;
    end
  end

  always_ff @(posedge core_clk_i) begin
    r <= r_nxt;
  end

endmodule

// File: dtc_gate_ctrl_properties.sv
// assertions on the ports of the gate control logic
`timescale 1ns/10ps
module dtc_gate_ctrl_props (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic so_oe_n_o,
  input wire logic gate_enable_first_i,
  input wire logic gate_enable_second_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic [2:0] phase_cmp_i,
  input wire logic oc_cmp_i,
  input wire logic high_gate_out_a_o,
  input wire logic high_gate_out_b_o,
  input wire logic high_gate_out_c_o,
  input wire logic low_gate_out_a_o,
  input wire logic low_gate_out_b_o,
  input wire logic low_gate_out_c_o,
  input wire logic gate_oe_n_o,
  input wire logic gate_pulldown_o,
  input wire logic phase_level_out_a_o,
  input wire logic fault_int_o,
  input wire logic overcurrent_flag_out_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  logic [3:0] q_r;
  logic pa_r;
  logic [5:0] g;
  assign g = {high_gate_out_a_o, high_gate_out_b_o, high_gate_out_c_o,
    low_gate_out_a_o, low_gate_out_b_o, low_gate_out_c_o};
  // clean cycles since any reset; low side a seen on since enable
  always_ff @(posedge core_clk_i) begin
    q_r <= (reset_i || !rst_n_i || !por_n_i) ? 4'h0 : q_r + {3'h0, q_r != 4'hF};
    pa_r <= (q_r == 4'h0 || !gate_enable_first_i || !gate_enable_second_i) ? 1'h0 : pa_r | low_gate_out_a_o;
  end
  gate_enable_a: assert property (
    !(gate_enable_first_i && gate_enable_second_i) |-> g == 6'h00) else $error("gate on while disabled");
  reset_pin_a: assert property (
    !rst_n_i |-> gate_pulldown_o && g == 6'h00) else $error("gate on in reset");
  reset_time_a: assert property (
    $fell(rst_n_i) ##1 !rst_n_i [*7] |-> !fault_int_o && !overcurrent_flag_out_o) else $error("slow reset");
  por_hiz_a: assert property (
    !por_n_i |-> gate_oe_n_o && so_oe_n_o && g == 6'h00) else $error("driven in clear");
  so_drive_a: assert property (
    so_oe_n_o == (cs_n_i || !por_n_i)) else $error("serial enable wrong");
  phase_follow_a: assert property (
    q_r == 4'hF |-> phase_level_out_a_o == $past(phase_cmp_i[0], 3)) else $error("phase level wrong");
  oc_follow_a: assert property (
    q_r == 4'hF |-> overcurrent_flag_out_o == $past(oc_cmp_i, 3)) else $error("overcurrent wrong");
  low_first_a: assert property (
    high_gate_out_a_o |-> pa_r) else $error("high before low");
endmodule
bind dtc_gate_ctrl dtc_gate_ctrl_props props_i (
  .core_clk_i(core_clk_i),
  .reset_i(reset_i),
  .cs_n_i(cs_n_i),
  .so_oe_n_o(so_oe_n_o),
  .gate_enable_first_i(gate_enable_first_i),
  .gate_enable_second_i(gate_enable_second_i),
  .rst_n_i(rst_n_i),
  .por_n_i(por_n_i),
  .phase_cmp_i(phase_cmp_i),
  .oc_cmp_i(oc_cmp_i),
  .high_gate_out_a_o(high_gate_out_a_o),
  .high_gate_out_b_o(high_gate_out_b_o),
  .high_gate_out_c_o(high_gate_out_c_o),
  .low_gate_out_a_o(low_gate_out_a_o),
  .low_gate_out_b_o(low_gate_out_b_o),
  .low_gate_out_c_o(low_gate_out_c_o),
  .gate_oe_n_o(gate_oe_n_o),
  .gate_pulldown_o(gate_pulldown_o),
  .phase_level_out_a_o(phase_level_out_a_o),
  .fault_int_o(fault_int_o),
  .overcurrent_flag_out_o(overcurrent_flag_out_o)
);

// File: dtc_host_model.sv
// host side serial master sending framed words
`timescale 1ns/10ps
module dtc_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  initial {sclk_o, cs_n_o, si_o} = 3'h2;
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n_o = 1'h0;
    #100;
    for (int k = 15; k >= 0; k--) begin
      sclk_o = 1'h1;
      si_o = w[k];
      #16;
      sclk_o = 1'h0;
      r[k] = so_i;
      #16;
    end
    #84;
    {cs_n_o, si_o} = 2'h2;
    #1000;
  endtask
endmodule

// File: dtc_gate_ctrl_tb.sv
// self-checking bench of the gate control logic
`timescale 1ns/10ps
module dtc_gate_ctrl_tb;
  logic core_clk_i, reset_i, sclk, cs_n, si, so, so_oe_n, en1, en2, rst_n, por_n, oc, goe_n, pd, irq, ocf;
  logic [2:0] hs_n, ls, cmp;
  wire [2:0] hg, lg, ph;
  logic [7:0] flt;
  logic [15:0] r;
  int num_errors = 0;
  int check_count = 0;
  int n;
  // comparator and overcurrent inputs in the high nibble, expected outputs in the low one
  logic [7:0] rows [8] = '{8'h00, 8'h11, 8'h22, 8'h44, 8'h88, 8'h55, 8'hEE, 8'hFF};
  // deadtime data beside cycles from low side edge to low gate on
  int dt [3][2] = '{'{255, 1204}, '{4, 24}, '{0, 4}};
  dtc_gate_ctrl uut (.core_clk_i(core_clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .so_o(so), .so_oe_n_o(so_oe_n), .gate_enable_first_i(en1), .gate_enable_second_i(en2), .rst_n_i(rst_n),
    .por_n_i(por_n), .high_side_cmd_n_a_i(hs_n[0]), .high_side_cmd_n_b_i(hs_n[1]), .high_side_cmd_n_c_i(hs_n[2]),
    .low_side_cmd_a_i(ls[0]), .low_side_cmd_b_i(ls[1]), .low_side_cmd_c_i(ls[2]), .phase_cmp_i(cmp),
    .fault_src_i(flt), .oc_cmp_i(oc), .high_gate_out_a_o(hg[0]), .high_gate_out_b_o(hg[1]),
    .high_gate_out_c_o(hg[2]), .low_gate_out_a_o(lg[0]), .low_gate_out_b_o(lg[1]), .low_gate_out_c_o(lg[2]),
    .gate_oe_n_o(goe_n), .gate_pulldown_o(pd), .phase_level_out_a_o(ph[0]), .phase_level_out_b_o(ph[1]),
    .phase_level_out_c_o(ph[2]), .fault_int_o(irq), .overcurrent_flag_out_o(ocf));
  dtc_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask
  task automatic cmd(input logic [15:0] w);
    host.xfer(w, r);
    cyc(1);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    reset_i = 1'h1;
    {en1, en2, oc, cmp, ls, flt} = '0;
    // power-on clear at start also clears the link registers
    {rst_n, por_n, hs_n} = 5'h17;
    cyc(2);
    {reset_i, por_n} = 2'h1;
    foreach (rows[i]) begin
      {cmp, oc} = rows[i][7:4];
      cyc(4);
      chk({ph, ocf}, rows[i][3:0]);
    end
    $display("test rows done");
    reset_i = 1'h1;
    cyc(2);
    reset_i = 1'h0;
    chk({hg, lg, ph, irq, ocf, goe_n, pd, so_oe_n}, 16'h0001);
    {cmp, oc, en1, en2} = 6'h03;
    cyc(5);
    hs_n = 3'h0;
    cyc(40);
    chk(hg, 3'h0);
    hs_n = 3'h7;
    for (int i = 0; i < 3; i++) begin
      cmd(16'h4000 + 16'(dt[i][0]));
      ls = 3'h7;
      n = 0;
      while (lg[0] !== 1'h1 && n < 1300) begin
        cyc(1);
        n++;
      end
      chk(16'(n), 16'(dt[i][1]));
      chk(lg, 3'h7);
      ls = 3'h0;
      cyc(4);
      chk(lg, 3'h0);
    end
    hs_n = 3'h6;
    cyc(6);
    chk(hg, 3'h1);
    ls = 3'h1;
    cyc(3);
    chk(hg, 3'h0);
    {ls, hs_n} = 6'h07;
    cyc(4);
    hs_n = 3'h6;
    cyc(6);
    chk(hg, 3'h1);
    en2 = 1'h0;
    #1 chk(hg, 3'h0);
    // hold the enable low past the synchroniser so the core drops priming
    cyc(3);
    {en2, hs_n} = 4'hF;
    cyc(2);
    hs_n = 3'h6;
    cyc(10);
    chk(hg, 3'h0);
    hs_n = 3'h7;
    $display("test gates done");
    flt = 8'h01;
    cyc(5);
    chk(irq, 1'h1);
    flt = 8'h00;
    cyc(20);
    chk(irq, 1'h1);
    cmd(16'h0000);
    chk(r[15], 1'h1);
    cmd(16'h1000);
    chk(irq, 1'h0);
    cmd(16'h2001);
    cmd(16'h3001);
    flt = 8'h11;
    cyc(10);
    chk(irq, 1'h0);
    cmd(16'h3000);
    chk(irq, 1'h1);
    cmd(16'h5001);
    cmd(16'h5000);
    cmd(16'h0000);
    chk(r[14:13], 2'h3);
    $display("test serial done");
    oc = 1'h1;
    cyc(5);
    rst_n = 1'h0;
    cyc(8);
    chk({pd, irq, ocf, hg, lg}, 9'h100);
    {rst_n, flt, oc} = 10'h200;
    cyc(10);
    cmd(16'h0000);
    chk(r[15:13], 3'h0);
    por_n = 1'h0;
    #1 chk({goe_n, so_oe_n, hg}, 5'h18);
    cyc(1);
    por_n = 1'h1;
    $display("test reset pins done");
    stop_test();
  end
endmodule
